// ---- rtl/cdr_regs.sv ----
// Comparator control and reference register bank behind an AHB-Lite slave
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Each reference register stores a read/write 10-bit level code, zero after reset, with bits 15..10 reading zero.
// - The level code spans 1024 steps of a full scale picked by the range bit, internal reference or half supply.
// - A code of zero gives a zero volt threshold in either range.
// - The four channels sit from index 04C0 to 04CE, control then reference, every register resetting to zero.
module cdr_regs (
    // Clock and reset
    input  wire logic                                     sys_clk,
    input  wire logic                                     rst_b,
    // AHB-Lite slave
    input  wire logic                                     hsel,
    input  wire logic [31:0]                              haddr,
    input  wire logic [1:0]                               htrans,
    input  wire logic                                     hwrite,
    input  wire logic [2:0]                               hsize,
    input  wire logic [31:0]                              hwdata,
    input  wire logic                                     hready,
    output logic                                          hreadyout,
    output logic                                          hresp,
    output logic [31:0]                                   hrdata,
    // Comparator side
    input  wire logic [cdr_pkg::CDR_CHANNELS-1:0]         cmp_status,
    output cdr_pkg::cdr_dac_s [cdr_pkg::CDR_CHANNELS-1:0] dac_out
);
    import cdr_pkg::*;

    cdr_state_s  st_r;
    cdr_state_s  st_nxt;
    logic        acc;
    logic        hit;
    logic [11:0] idx;
    logic [1:0]  chan;
    logic [15:0] rd_word;

    // Address phase decode; odd or out-of-range indices are unmapped
    assign idx  = haddr[13:2];
    assign chan = idx[3:2];
    assign acc  = hsel & hready & (htrans == CDR_HTRANS_NONSEQ || htrans == CDR_HTRANS_SEQ);
    assign hit  = (haddr[31:14] == 18'h00000) && (idx[11:4] == CDR_IDX_BASE_HI)
                  && (idx[0] == 1'b0) && (haddr[1:0] == 2'h0);

    // Next state: apply pending write, then read from the updated copy
    always_comb begin
        st_nxt = st_r;
        rd_word = 16'h0000;
        // Data phase write lands here, one cycle after its address phase
        if (st_r.wr_pend) begin
            if (st_r.wr_ctl) begin
                st_nxt.ctl[st_r.wr_chan] = (st_r.ctl[st_r.wr_chan] & ~CDR_CTL_WMASK)
                                           | (hwdata[15:0] & CDR_CTL_WMASK);
            end else begin
                // only the low ten bits are stored
                st_nxt.ref_code[st_r.wr_chan] = hwdata[CDR_CODE_W-1:0];
            end
        end
        // Status bit is hardware owned and follows the comparator
        for (int i = 0; i < CDR_CHANNELS; i++) begin
            st_nxt.ctl[i][CDR_CTL_STAT] = cmp_status[i];
        end
        st_nxt.wr_pend = acc & hit & hwrite;
        st_nxt.wr_ctl  = ~idx[1];
        st_nxt.wr_chan = chan;
        // Forwarded read avoids stale data right after a write
        if (acc & hit & ~hwrite) begin
            if (idx[1]) begin
                rd_word = {6'h00, st_nxt.ref_code[chan]};
            end else begin
                rd_word = st_nxt.ctl[chan];
            end
        end
        st_nxt.rdata = {16'h0000, rd_word};
        if (!rst_b) begin
            for (int i = 0; i < CDR_CHANNELS; i++) begin
                st_nxt.ctl[i]      = CDR_CTL_RESET;
                st_nxt.ref_code[i] = CDR_REF_RESET;
            end
            st_nxt.wr_pend = 1'b0;
            st_nxt.wr_ctl  = 1'b0;
            st_nxt.wr_chan = 2'h0;
            st_nxt.rdata   = 32'h00000000;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        st_r <= st_nxt;
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_r.rdata;

    // Converter drive straight from the stored registers
    always_comb begin
        for (int i = 0; i < CDR_CHANNELS; i++) begin
            // range bit picks the full-scale source for the 1024 steps
            dac_out[i].range_sel      = st_r.ctl[i][CDR_CTL_RANGE];
            // code presented continuously; zero code means zero volts
            dac_out[i].ref_level_code = st_r.ref_code[i];
        end
    end
endmodule
`default_nettype wire

// ---- rtl/cdr_pkg.sv ----
// Package of constants and types for the comparator reference register bank
package cdr_pkg;
    localparam int          CDR_CHANNELS   = 4;
    localparam int          CDR_CODE_W     = 10;
    localparam int          CDR_STEPS      = 1024;
    // Register indices as printed; byte address is four times the index
    localparam logic [11:0] CDR_IDX_C1_CTL = 12'h4C0;
    localparam logic [11:0] CDR_IDX_C1_REF = 12'h4C2;
    localparam logic [11:0] CDR_IDX_C2_CTL = 12'h4C4;
    localparam logic [11:0] CDR_IDX_C2_REF = 12'h4C6;
    localparam logic [11:0] CDR_IDX_C3_CTL = 12'h4C8;
    localparam logic [11:0] CDR_IDX_C3_REF = 12'h4CA;
    localparam logic [11:0] CDR_IDX_C4_CTL = 12'h4CC;
    localparam logic [11:0] CDR_IDX_C4_REF = 12'h4CE;
    localparam logic [7:0]  CDR_IDX_BASE_HI = 8'h4C;
    // Field positions of the control register
    localparam int          CDR_CTL_ON     = 15;
    localparam int          CDR_CTL_IDLE   = 13;
    localparam int          CDR_CTL_INSEL  = 6;
    localparam int          CDR_CTL_EXTREF = 5;
    localparam int          CDR_CTL_STAT   = 3;
    localparam int          CDR_CTL_POL    = 1;
    localparam int          CDR_CTL_RANGE  = 0;
    // Writable control bits: on, idle stop, input select, ext ref, polarity, range
    localparam logic [15:0] CDR_CTL_WMASK  = 16'hA0E3;
    localparam logic [15:0] CDR_CTL_RESET  = 16'h0000;
    localparam logic [9:0]  CDR_REF_RESET  = 10'h000;
    localparam logic [1:0]  CDR_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  CDR_HTRANS_SEQ    = 2'h3;

    // Per-channel drive toward the analog reference
    typedef struct packed {
        logic                  range_sel;
        logic [CDR_CODE_W-1:0] ref_level_code;
    } cdr_dac_s;

    // Whole state of the bank
    typedef struct packed {
        logic [CDR_CHANNELS-1:0][15:0]           ctl;
        logic [CDR_CHANNELS-1:0][CDR_CODE_W-1:0] ref_code;
        logic                                    wr_pend;
        logic                                    wr_ctl;
        logic [1:0]                              wr_chan;
        logic [31:0]                             rdata;
    } cdr_state_s;
endpackage

// ---- verif/cdr_regs_assertions.sv ----
// Checker bound to the comparator reference bank
`timescale 1ns/100ps
`default_nettype none
module cdr_regs_assertions import cdr_pkg::*; (
    // Watched ports
    input wire logic        sys_clk, rst_b, hsel, hwrite,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] haddr, hwdata, hrdata,
    input wire cdr_pkg::cdr_dac_s [cdr_pkg::CDR_CHANNELS-1:0] dac_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Address phase decode; hready is always high here
    wire logic rd = hsel && htrans[1] && !hwrite;
    wire logic wr = hsel && htrans[1] && hwrite;
    property p_hi0; rd && haddr[31:6] == 26'h4C && haddr[3:0] == 4'h8 |=> hrdata[31:10] == 22'h0; endproperty
    a_hi0: assert property (p_hi0) else $error("reference read shows upper bits");
    property p_gap0; rd && haddr == 32'h1304 |=> hrdata == 32'h0; endproperty
    a_gap0: assert property (p_gap0) else $error("unmapped read not zero");
    property p_rst0; $rose(rst_b) |-> dac_out == '0 && hrdata == 32'h0; endproperty
    a_rst0: assert property (p_rst0) else $error("bank not clear after reset");
    property p_dac_wr; wr && haddr == 32'h1308 ##1 1'b1 |=> dac_out[0].ref_level_code == $past(hwdata[9:0]); endproperty
    a_dac_wr: assert property (p_dac_wr) else $error("converter code not the written one");
    property p_dac_hold; !$stable(dac_out) |-> $past(wr, 2); endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("converter drive moved without a write");
    // Main scenarios reached
    c_wr_ref: cover property (wr && haddr == 32'h1308);
    c_gap: cover property (rd && haddr == 32'h1304);
    c_rng: cover property ($rose(dac_out[1].range_sel));
endmodule
bind cdr_regs cdr_regs_assertions u_chk (.sys_clk, .rst_b, .hsel, .hwrite, .htrans, .haddr, .hwdata, .hrdata, .dac_out);
`default_nettype wire

// ---- verif/cdr_regs_test.sv ----
// Self-checking bench for the comparator reference bank
`timescale 1ns/100ps
`default_nettype none
module cdr_regs_test;
    import cdr_pkg::*;
    logic                        sys_clk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic [1:0]                  htrans;
    logic [2:0]                  hsize;
    logic [31:0]                 haddr, hwdata, hrdata, rd_v, a;
    logic [3:0]                  cmp_status;
    cdr_dac_s [CDR_CHANNELS-1:0] dac_out;
    int                          n_fail, total_checks, cyc;
    cdr_regs dut (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
                  .hreadyout, .hresp, .hrdata, .cmp_status, .dac_out);
    // Clock, and a ceiling far above the 57 cycles used
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single transfer; read data taken at the end of the data phase
    task automatic xfer(input logic w, input logic [31:0] ad, d);
        {hsel, hwrite, haddr, htrans} <= {1'b1, w, ad, CDR_HTRANS_NONSEQ};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd_v = hrdata;
        chk(32'(hresp), 32'h0);
    endtask
    // Reset value, ten bit code and converter drive per channel
    task automatic t_ref();
        for (int k = 0; k < 4; k++) begin
            a = 32'h1308 + 32'(k) * 32'h10;
            xfer(1'b0, a, 32'h0);
            chk(rd_v, 32'h0);
            xfer(1'b1, a, 32'hFFFF_FFFF - 32'(k));
            xfer(1'b0, a, 32'h0);
            chk(rd_v, 32'h3FF - 32'(k));
            chk(32'(dac_out[k].ref_level_code), 32'h3FF - 32'(k));
        end
    endtask
    // Control mask, status, range select, zero code and a hole in the map
    task automatic t_ctl();
        cmp_status <= 4'h5;
        for (int k = 0; k < 4; k++) begin
            a = 32'h1300 + 32'(k) * 32'h10;
            xfer(1'b0, a, 32'h0);
            chk(rd_v, (k % 2 == 0) ? 32'h8 : 32'h0);
            xfer(1'b1, a, 32'hFFFF_FFFF);
            xfer(1'b0, a, 32'h0);
            chk(rd_v, (k % 2 == 0) ? 32'hA0EB : 32'hA0E3);
            chk(32'(dac_out[k].range_sel), 32'h1);
        end
        xfer(1'b1, 32'h1308, 32'h0);
        xfer(1'b1, 32'h1304, 32'hFFFF_FFFF);
        xfer(1'b0, 32'h1304, 32'h0);
        chk(32'(dac_out[0]), 32'h400);
        chk(rd_v, 32'h0);
    endtask
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hold reset two cycles, then run the scenarios
    initial begin
        {rst_b, hsel, hwrite, htrans, haddr, hwdata, cmp_status} = '0;
        hsize = 3'h2;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_ref();
        t_ctl();
        print_verdict();
    end
endmodule
`default_nettype wire
